// File: fth_pkg.sv
// Purpose: shared constants for the fault trip and history block
// Assumes: 100 MHz controller clock; codes held as two BCD digits
// Notes:   fault source indices give pin positions only; trip priority is set by the fault selection order
package fth_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned STOP_CHECK_S  = 100;
  localparam int unsigned CNT_W         = 40;
  localparam int unsigned CODE_W        = 8;

  // error codes as shown on the display
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_OC_CONST  = 8'h01;
  localparam logic [7:0] CODE_OC_DECEL  = 8'h02;
  localparam logic [7:0] CODE_OC_ACCEL  = 8'h03;
  localparam logic [7:0] CODE_OC_OTHER  = 8'h04;
  localparam logic [7:0] CODE_OVERLOAD  = 8'h05;
  localparam logic [7:0] CODE_DC_OVERV  = 8'h07;
  localparam logic [7:0] CODE_MEMORY    = 8'h08;
  localparam logic [7:0] CODE_DC_UNDERV = 8'h09;
  localparam logic [7:0] CODE_CPU       = 8'h11;
  localparam logic [7:0] CODE_EXT_TRIP  = 8'h12;
  localparam logic [7:0] CODE_START_GRD = 8'h13;
  localparam logic [7:0] CODE_GROUND    = 8'h14;
  localparam logic [7:0] CODE_IN_OVERV  = 8'h15;
  localparam logic [7:0] CODE_MOD_TEMP  = 8'h21;
  localparam logic [7:0] CODE_DRIVER    = 8'h30;
  localparam logic [7:0] CODE_THERMIST  = 8'h35;
  localparam logic [7:0] CODE_SAFE_STOP = 8'h37;
  localparam logic [7:0] CODE_COMM_WDT  = 8'h60;

  localparam logic [7:0] INIT_CLEAR_HIST = 8'h00;

  // motion state encoding
  localparam logic [1:0] MOTION_CONST = 2'h0;
  localparam logic [1:0] MOTION_DECEL = 2'h1;
  localparam logic [1:0] MOTION_ACCEL = 2'h2;

  // synchronised pin positions
  localparam int unsigned PIN_OC       = 0;
  localparam int unsigned PIN_OVERLOAD = 1;
  localparam int unsigned PIN_DC_OVERV = 2;
  localparam int unsigned PIN_MEMORY   = 3;
  localparam int unsigned PIN_DC_UNDER = 4;
  localparam int unsigned PIN_CPU      = 5;
  localparam int unsigned PIN_EXT      = 6;
  localparam int unsigned PIN_GND_FAIL = 7;
  localparam int unsigned PIN_IN_OVERV = 8;
  localparam int unsigned PIN_MOD_TEMP = 9;
  localparam int unsigned PIN_THERMIST = 10;
  localparam int unsigned PIN_DRIVER   = 11;
  localparam int unsigned PIN_SAFE     = 12;
  localparam int unsigned PIN_RUN_CMD  = 13;
  localparam int unsigned PIN_KEY      = 14;
  localparam int unsigned PIN_COMM_ACT = 15;
  localparam int unsigned PIN_GND_DONE = 16;
  localparam int unsigned PIN_RST_TERM = 17;
  localparam int unsigned PIN_COUNT    = 18;

  typedef enum logic [1:0] {
    ST_POWERUP  = 2'b00,
    ST_NORMAL   = 2'b01,
    ST_BROWNOUT = 2'b10
  } pwr_state_e;

endpackage

// File: input_sync.sv
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  initial begin
    if (W < 1) $error("input_sync: width must be at least 1");
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;
endmodule
`default_nettype wire

// File: fault_history.sv
// Purpose: three-deep trip history with operating snapshot per entry
// Assumes: push and clear come from the trip logic on the same clock
// Notes:   a push in the clear cycle is kept as the only entry
`timescale 1ns/1ps
`default_nettype none
module fault_history
  import fth_pkg::*;
#(
  parameter int unsigned SNAP_W = 48
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              push,
  input  wire logic              clear,
  input  wire logic [CODE_W-1:0] new_code,
  input  wire logic [SNAP_W-1:0] new_snap,
  output logic      [CODE_W-1:0] hist_code [3],
  output logic      [SNAP_W-1:0] hist_snap [3]
);
  logic [CODE_W-1:0] code_q [3];
  logic [CODE_W-1:0] code_d [3];
  logic [SNAP_W-1:0] snap_q [3];
  logic [SNAP_W-1:0] snap_d [3];

  initial begin
    if (SNAP_W < 1) $error("fault_history: snapshot width too small");
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      code_d[i] = clear ? CODE_NONE : code_q[i];
      snap_d[i] = clear ? '0 : snap_q[i];
    end
    if (push) begin
      for (int i = 2; i > 0; i--) begin
        code_d[i] = clear ? CODE_NONE : code_q[i-1];
        snap_d[i] = clear ? '0 : snap_q[i-1];
      end
      code_d[0] = new_code;
      snap_d[0] = new_snap;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        code_q[i] <= CODE_NONE;
        snap_q[i] <= '0;
      end
    end else begin
      code_q <= code_d;
      snap_q <= snap_d;
    end
  end

  assign hist_code = code_q;
  assign hist_snap = snap_q;
endmodule
`default_nettype wire

// File: fault_trip_history.sv
// Purpose: fault trip latch, error code display and trip history
// Assumes: fault and key pins are asynchronous; motion data is local
// Notes:   reset release stands for power being applied
//
// Summary of operation
// - any detected fault latches a trip, drive off, event recorded
// - internal faults trip also while the motor is stopped
// - the stop/reset key clears a latched trip
// - selector value 00 applied empties history, nothing else changes
// - over-current code by motion: const 01, decel 02, accel 03, else 04
// - motor overload reports 05, DC bus over-voltage reports 07
// - parameter memory fault reports 08, DC bus under-voltage 09
// - start guard: run command at power-up trips 13, blocks running
// - failed power-up ground-fault test trips with code 14
// - after 100 s stopped, input over-voltage trips with code 15
// - power module over-temperature trips 21, thermistor trips 35
// - driver protection path error shuts output, reports 30
// - safety stop signal trips with code 37
// - communications watchdog expiry trips with code 60
// - every trip shows its error code on the display at once
// - low input voltage: output off, restart; trip only if restart fails
// - reset terminal active at power loss raises memory error at power-up
// - each trip stores a snapshot of operating data with its record
// - three-entry history, newest shifts to middle, middle to oldest
`timescale 1ns/1ps
`default_nettype none
module fault_trip_history
  import fth_pkg::*;
#(
  parameter longint unsigned STOP_CHECK_CYCLES =
    longint'(STOP_CHECK_S) * longint'(CLK_HZ),
  parameter int unsigned     COMM_TIMEOUT_CYCLES = 100_000,
  parameter int unsigned     RESTART_WAIT_CYCLES = 1_000,
  parameter int unsigned     SNAP_W              = 48
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      overcurrent_pin,
  input  wire logic                      overload_pin,
  input  wire logic                      dc_overvolt_pin,
  input  wire logic                      memory_fault_pin,
  input  wire logic                      dc_undervolt_pin,
  input  wire logic                      cpu_fault_pin,
  input  wire logic                      external_trip_input,
  input  wire logic                      ground_test_fail_pin,
  input  wire logic                      ground_test_done_pin,
  input  wire logic                      input_overvolt_pin,
  input  wire logic                      module_overtemp_pin,
  input  wire logic                      thermistor_hot_pin,
  input  wire logic                      driver_error_pin,
  input  wire logic                      safety_stop_pin,
  input  wire logic                      run_command_pin,
  input  wire logic                      stop_reset_key,
  input  wire logic                      comm_activity_pin,
  input  wire logic                      reset_input_terminal,
  input  wire logic                      unattended_start_guard,
  input  wire logic                      comm_watchdog_en,
  input  wire logic                      motor_running,
  input  wire logic [1:0]                motion_state,
  input  wire logic [SNAP_W-1:0]         operating_data,
  input  wire logic [7:0]                initialization_selector,
  input  wire logic                      init_apply,
  output logic                           drive_enable,
  output logic                           tripped,
  output logic [CODE_W-1:0]              display_code,
  output logic [CODE_W-1:0]              newest_fault_record,
  output logic [CODE_W-1:0]              middle_fault_record,
  output logic [CODE_W-1:0]              oldest_fault_record,
  output logic [SNAP_W-1:0]              newest_fault_snapshot,
  output logic [SNAP_W-1:0]              middle_fault_snapshot,
  output logic [SNAP_W-1:0]              oldest_fault_snapshot
);
  import fth_pkg::*;

  localparam logic [CNT_W-1:0] STOP_LIMIT = CNT_W'(STOP_CHECK_CYCLES);
  localparam logic [31:0] COMM_LIMIT = 32'(COMM_TIMEOUT_CYCLES);
  localparam logic [31:0] RESTART_LIMIT = 32'(RESTART_WAIT_CYCLES);

  initial begin
    if (STOP_CHECK_CYCLES < 1 || STOP_CHECK_CYCLES >= (64'h1 << CNT_W))
      $error("fault_trip_history: stop check count out of range");
    if (COMM_TIMEOUT_CYCLES < 1 || RESTART_WAIT_CYCLES < 1)
      $error("fault_trip_history: timeout counts must be nonzero");
  end

  // pin synchronisation
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] s;

  assign pins = {reset_input_terminal, ground_test_done_pin,
                 comm_activity_pin, stop_reset_key, run_command_pin,
                 safety_stop_pin, driver_error_pin, thermistor_hot_pin,
                 module_overtemp_pin, input_overvolt_pin,
                 ground_test_fail_pin, external_trip_input, cpu_fault_pin,
                 dc_undervolt_pin, memory_fault_pin, dc_overvolt_pin,
                 overload_pin, overcurrent_pin};

  input_sync #(.W(PIN_COUNT)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   (pins),
    .pin_sync (s)
  );

  function automatic logic [CODE_W-1:0] oc_code(input logic [1:0] m);
    unique case (m)
      MOTION_CONST: oc_code = CODE_OC_CONST;
      MOTION_DECEL: oc_code = CODE_OC_DECEL;
      MOTION_ACCEL: oc_code = CODE_OC_ACCEL;
      default:      oc_code = CODE_OC_OTHER;
    endcase
  endfunction

  // state
  pwr_state_e        st_q,      st_d;
  logic              trip_q,    trip_d;
  logic [CODE_W-1:0] code_q,    code_d;
  logic              key_q,     key_d;
  logic              act_q,     act_d;
  logic [CNT_W-1:0]  stop_q,    stop_d;
  logic [31:0]       wdt_q,     wdt_d;
  logic [31:0]       bo_q,      bo_d;
  logic              drive_q,   drive_d;
  logic              block_q,   block_d;

  logic              key_press;
  logic              fault_any;
  logic [CODE_W-1:0] fault_code;
  logic              hist_clear;
  logic              trip_set;
  logic              stop_elapsed;
  logic              wdt_expired;
  logic              restart_failed;
  logic [CODE_W-1:0] hist_code [3];
  logic [SNAP_W-1:0] hist_snap [3];

  assign key_press      = s[PIN_KEY] && !key_q;
  assign stop_elapsed   = stop_q >= STOP_LIMIT;
  assign wdt_expired    = comm_watchdog_en && wdt_q >= COMM_LIMIT;
  assign restart_failed = st_q == ST_BROWNOUT && bo_q >= RESTART_LIMIT
                          && s[PIN_DC_UNDER];
  assign hist_clear     = init_apply
                          && initialization_selector == INIT_CLEAR_HIST;

  // fault selection, highest priority first; later checks apply only if none matched
  always_comb begin
    fault_any  = 1'b1;
    fault_code = CODE_NONE;
    if (st_q == ST_POWERUP) begin
      if (s[PIN_GND_DONE] && s[PIN_GND_FAIL])
        fault_code = CODE_GROUND;
      else if (s[PIN_GND_DONE] && unattended_start_guard && s[PIN_RUN_CMD])
        fault_code = CODE_START_GRD;
      else if (s[PIN_GND_DONE] && s[PIN_RST_TERM])
        fault_code = CODE_MEMORY;
    end
    if (fault_code == CODE_NONE) begin
      // faults below are checked in run and stop alike, except input over-voltage, which needs the stop time
      if (s[PIN_SAFE])           fault_code = CODE_SAFE_STOP;
      else if (s[PIN_DRIVER])    fault_code = CODE_DRIVER;
      else if (s[PIN_CPU])       fault_code = CODE_CPU;
      else if (s[PIN_MEMORY])    fault_code = CODE_MEMORY;
      else if (s[PIN_OC])        fault_code = oc_code(motion_state);
      else if (s[PIN_DC_OVERV])  fault_code = CODE_DC_OVERV;
      else if (s[PIN_OVERLOAD])  fault_code = CODE_OVERLOAD;
      else if (s[PIN_MOD_TEMP])  fault_code = CODE_MOD_TEMP;
      else if (s[PIN_THERMIST])  fault_code = CODE_THERMIST;
      else if (s[PIN_EXT])       fault_code = CODE_EXT_TRIP;
      else if (restart_failed)   fault_code = CODE_DC_UNDERV;
      else if (wdt_expired)      fault_code = CODE_COMM_WDT;
      else if (stop_elapsed && s[PIN_IN_OVERV])
        fault_code = CODE_IN_OVERV;
      else
        fault_any = 1'b0;
    end
  end

  // a new fault in the clearing cycle re-latches at once
  assign trip_set = fault_any && (!trip_q || key_press);

  always_comb begin
    st_d    = st_q;
    trip_d  = trip_q;
    code_d  = code_q;
    key_d   = s[PIN_KEY];
    act_d   = s[PIN_COMM_ACT];
    stop_d  = stop_q;
    wdt_d   = wdt_q;
    bo_d    = bo_q;
    block_d = block_q;
    if (trip_set) begin
      trip_d = 1'b1;
      code_d = fault_code;
      if (fault_code == CODE_START_GRD)
        block_d = 1'b1;
    end else if (key_press && trip_q) begin
      trip_d  = 1'b0;
      code_d  = CODE_NONE;
      block_d = 1'b0;
    end
    unique case (st_q)
      ST_POWERUP: begin
        if (s[PIN_GND_DONE])
          st_d = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (s[PIN_DC_UNDER]) begin
          st_d = ST_BROWNOUT;
          bo_d = '0;
        end
      end
      ST_BROWNOUT: begin
        if (!s[PIN_DC_UNDER])
          st_d = ST_NORMAL;
        else if (restart_failed)
          st_d = ST_NORMAL;
        else
          bo_d = bo_q + 32'h1;
      end
      default: st_d = ST_POWERUP;
    endcase
    if (motor_running || trip_q)
      stop_d = '0;
    else if (!stop_elapsed)
      stop_d = stop_q + CNT_W'(1);
    if (!comm_watchdog_en || (s[PIN_COMM_ACT] && !act_q) || trip_q)
      wdt_d = '0;
    else if (!wdt_expired)
      wdt_d = wdt_q + 32'h1;
  end

  assign drive_d = !trip_d && !block_d && st_d == ST_NORMAL;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ST_POWERUP;
      trip_q  <= 1'b0;
      code_q  <= CODE_NONE;
      key_q   <= 1'b0;
      act_q   <= 1'b0;
      stop_q  <= '0;
      wdt_q   <= '0;
      bo_q    <= '0;
      drive_q <= 1'b0;
      block_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      trip_q  <= trip_d;
      code_q  <= code_d;
      key_q   <= key_d;
      act_q   <= act_d;
      stop_q  <= stop_d;
      wdt_q   <= wdt_d;
      bo_q    <= bo_d;
      drive_q <= drive_d;
      block_q <= block_d;
    end
  end

  // history only pushes on trips; key clears never touch it
  fault_history #(.SNAP_W(SNAP_W)) u_hist (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .push      (trip_set),
    .clear     (hist_clear),
    .new_code  (fault_code),
    .new_snap  (operating_data),
    .hist_code (hist_code),
    .hist_snap (hist_snap)
  );

  assign drive_enable          = drive_q;
  assign tripped               = trip_q;
  assign display_code          = code_q;
  assign newest_fault_record   = hist_code[0];
  assign middle_fault_record   = hist_code[1];
  assign oldest_fault_record   = hist_code[2];
  assign newest_fault_snapshot = hist_snap[0];
  assign middle_fault_snapshot = hist_snap[1];
  assign oldest_fault_snapshot = hist_snap[2];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence trip_event;
    trip_set && !hist_clear;
  endsequence

  a_trip_drive_off: assert property (
    trip_set |=> tripped && !drive_enable)
    else $error("trip did not turn the drive off");

  a_trip_code_shown: assert property (
    trip_event |=> tripped && display_code == $past(fault_code))
    else $error("display code differs from trip cause");

  a_key_clears_trip: assert property (
    tripped && key_press && !fault_any |=> !tripped)
    else $error("key press did not clear trip");

  a_hist_shift_order: assert property (
    trip_event |=> newest_fault_record == $past(fault_code)
      && middle_fault_record == $past(newest_fault_record)
      && oldest_fault_record == $past(middle_fault_record))
    else $error("history did not shift correctly");

  a_hist_keep_clear: assert property (
    !trip_set && !hist_clear |=> $stable(newest_fault_record)
      && $stable(middle_fault_record) && $stable(oldest_fault_record))
    else $error("history changed without a trip");

  a_hist_clear_all: assert property (
    hist_clear && !trip_set |=> newest_fault_record == CODE_NONE
      && middle_fault_record == CODE_NONE && oldest_fault_record == CODE_NONE
      && $stable(tripped))
    else $error("history clear incomplete");

  a_snap_capture: assert property (
    trip_set |=> newest_fault_snapshot == $past(operating_data))
    else $error("snapshot not captured at trip");

  a_oc_by_motion: assert property (
    trip_set && s[PIN_OC] && fault_code[7:4] == 4'h0
      && fault_code != CODE_MEMORY
      |-> fault_code == CODE_OC_CONST + 8'(motion_state))
    else $error("over-current code does not match motion");

  a_safe_stop_trip: assert property (
    s[PIN_SAFE] && !tripped && st_q != ST_POWERUP
      |=> tripped && display_code == CODE_SAFE_STOP)
    else $error("safety stop did not trip with its code");

  a_brownout_off: assert property (
    st_q == ST_NORMAL && s[PIN_DC_UNDER] |=> !drive_enable
      ##0 (st_q == ST_BROWNOUT))
    else $error("brownout did not turn output off");

  a_guard_blocks: assert property (
    block_q && !key_press |=> !drive_enable)
    else $error("start guard allowed running");
endmodule
`default_nettype wire

// File: drive_partner.sv
// Purpose: output stage and keypad seen from the trip block
// Assumes: motor spins only while enabled and commanded
// Notes:   key request is presented one clock later on the key pin
`timescale 1ns/1ps
`default_nettype none
module drive_partner (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic drive_enable,
  input  wire logic run_command_pin,
  input  wire logic key_req,
  output logic      motor_running,
  output logic      stop_reset_key
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_running  <= 1'b0;
      stop_reset_key <= 1'b0;
    end else begin
      // motor stops on the clock after the output is cut
      motor_running  <= drive_enable & run_command_pin;
      stop_reset_key <= key_req;
    end
  end
endmodule
`default_nettype wire

// File: fault_trip_history_test.sv
// Purpose: self-checking bench for the fault trip and history block
// Assumes: short counts for stop check, watchdog and restart wait
// Notes:   history expectations come from a queue model
`timescale 1ns/1ps
`default_nettype none
module fault_trip_history_test;
  import fth_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0, key_req = 1'b0;
  logic        gnd_done = 1'b0, run_cmd = 1'b0, init_apply = 1'b0;
  logic        comm_act = 1'b0, rst_term = 1'b0, usg = 1'b0, wdt_en = 1'b0;
  logic [12:0] f = '0;
  logic [1:0]  motion = 2'h0;
  logic [47:0] data = '0;
  logic [7:0]  sel = 8'h01;
  logic        mot_run, key, drv, trp;
  logic [7:0]  disp, r0, r1, r2;
  logic [47:0] s0, s1, s2;
  int          miscompares = 0, check_count = 0, cyc = 0;
  logic [55:0] hq[$];
  logic [7:0]  code_tab [13] = '{8'h01, 8'h05, 8'h07, 8'h08, 8'h09,
    8'h11, 8'h12, 8'h21, 8'h35, 8'h30, 8'h37, 8'h14, 8'h15};
  always #5 sys_clk = ~sys_clk;
  fault_trip_history #(.STOP_CHECK_CYCLES(50), .COMM_TIMEOUT_CYCLES(20),
    .RESTART_WAIT_CYCLES(10), .SNAP_W(48)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .overcurrent_pin(f[0]),
    .overload_pin(f[1]), .dc_overvolt_pin(f[2]), .memory_fault_pin(f[3]),
    .dc_undervolt_pin(f[4]), .cpu_fault_pin(f[5]),
    .external_trip_input(f[6]), .module_overtemp_pin(f[7]),
    .thermistor_hot_pin(f[8]), .driver_error_pin(f[9]),
    .safety_stop_pin(f[10]), .ground_test_fail_pin(f[11]),
    .input_overvolt_pin(f[12]), .ground_test_done_pin(gnd_done),
    .run_command_pin(run_cmd), .stop_reset_key(key),
    .comm_activity_pin(comm_act), .reset_input_terminal(rst_term),
    .unattended_start_guard(usg), .comm_watchdog_en(wdt_en),
    .motor_running(mot_run), .motion_state(motion),
    .operating_data(data), .initialization_selector(sel),
    .init_apply(init_apply), .drive_enable(drv), .tripped(trp),
    .display_code(disp), .newest_fault_record(r0),
    .middle_fault_record(r1), .oldest_fault_record(r2),
    .newest_fault_snapshot(s0), .middle_fault_snapshot(s1),
    .oldest_fault_snapshot(s2));
  drive_partner PARTNER (
    .sys_clk(sys_clk), .rst_n(rst_n), .drive_enable(drv),
    .run_command_pin(run_cmd), .key_req(key_req),
    .motor_running(mot_run), .stop_reset_key(key));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [55:0] hx(input int i);
    return (i < hq.size()) ? hq[i] : 56'h0;
  endfunction
  task automatic chk_hist();
    chk({r0, s0}, hx(0));
    chk({r1, s1}, hx(1));
    chk({r2, s2}, hx(2));
  endtask
  task automatic press_key();
    key_req = 1'b1;
    cycles(4);
    key_req = 1'b0;
    cycles(4);
  endtask
  // wait for a latched trip, then check it against the model
  task automatic settle_check(input logic [7:0] e);
    cycles(20);
    hq.push_front({e, data});
    chk(trp, 1'b1);
    chk(drv, 1'b0);
    chk(disp, e);
    chk(s0, data);
    chk_hist();
  endtask
  task automatic clear_check();
    cycles(4);
    press_key();
    chk(trp, 1'b0);
    chk(disp, 8'h00);
    chk_hist();
  endtask
  // raise one fault, check latch, code, record, then clear by key
  task automatic fault(input int idx, input logic [1:0] ms);
    logic [7:0] e;
    e = (idx == 0) ? 8'h01 + 8'(ms) : code_tab[idx];
    motion = ms;
    data = 48'({$urandom, $urandom});
    run_cmd = 1'($urandom);
    cycles(3);
    f[idx] = 1'b1;
    settle_check(e);
    f[idx] = 1'b0;
    clear_check();
  endtask
  // power cycle with one power-up check armed, expect its trip
  task automatic power_up(input logic gf, input logic g, input logic r,
                          input logic [7:0] e);
    rst_n = 1'b0;
    gnd_done = 1'b0;
    f[11] = gf;
    usg = g;
    rst_term = r;
    run_cmd = 1'b1;
    data = 48'({$urandom, $urandom});
    cycles(2);
    rst_n = 1'b1;
    hq.delete();
    cycles(2);
    gnd_done = 1'b1;
    settle_check(e);
    f[11] = 1'b0;
    usg = 1'b0;
    rst_term = 1'b0;
    clear_check();
    chk(drv, 1'b1);
  endtask
  task automatic apply_sel(input logic [7:0] v);
    sel = v;
    init_apply = 1'b1;
    cycles(1);
    init_apply = 1'b0;
    cycles(2);
  endtask
  task automatic test_done();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    void'($urandom(3635));
    cycles(6);
    rst_n = 1'b1;
    cycles(2);
    gnd_done = 1'b1;
    cycles(8);
    chk(drv, 1'b1);
    chk(trp, 1'b0);
    for (int m = 0; m < 4; m++)
      fault(0, 2'(m));
    for (int i = 1; i < 11; i++)
      fault(i, 2'h3);
    run_cmd = 1'b0;
    fault(3, 2'h0);
    apply_sel(8'h5a);
    chk_hist();
    apply_sel(8'h00);
    hq.delete();
    chk_hist();
    chk(s0, 48'h0);
    chk(trp, 1'b0);
    fault(10, 2'h0);
    // short brownout: output off, restart without a trip
    f[4] = 1'b1;
    cycles(5);
    chk(drv, 1'b0);
    chk(trp, 1'b0);
    f[4] = 1'b0;
    cycles(6);
    chk(drv, 1'b1);
    chk(trp, 1'b0);
    // traffic keeps the watchdog quiet, silence lets it expire
    data = 48'({$urandom, $urandom});
    wdt_en = 1'b1;
    repeat (5) begin
      comm_act = 1'b1;
      cycles(4);
      comm_act = 1'b0;
      cycles(4);
    end
    chk(trp, 1'b0);
    settle_check(8'h60);
    wdt_en = 1'b0;
    clear_check();
    // input over-voltage only counts after a long stop
    data = 48'({$urandom, $urandom});
    run_cmd = 1'b1;
    cycles(3);
    f[12] = 1'b1;
    cycles(60);
    chk(trp, 1'b0);
    run_cmd = 1'b0;
    cycles(45);
    chk(trp, 1'b0);
    settle_check(8'h15);
    f[12] = 1'b0;
    clear_check();
    power_up(1'b1, 1'b0, 1'b0, 8'h14);
    power_up(1'b0, 1'b1, 1'b0, 8'h13);
    power_up(1'b0, 1'b0, 1'b1, 8'h08);
    test_done();
  end
endmodule
`default_nettype wire
